/* rtl/dcmc_top.sv */
// Function
// - Bit 7 reports comparator B comparison
// - Bit 6 reports comparator A comparison
// - Bit 5 inverts comparator B result
// - Bit 4 inverts comparator A result
// - Mode 010: switch picks both inverting sources
// - Mode 001: switch picks A inverting source
// - Mode 101: switch routes reference to B
// - Modes 000/111 off; analog versus digital pins
// - Modes 001/010 multiplex three/four pins
// - Mode 011 shared reference, 100 independent
// - 101 single comparator; 110 shared, outputs driven
// - Mode bits 2:0, switch bit 3, reset zero
module dcmc_top #(
    parameter int SYNC_DEPTH = dcmc_pkg::SYNC_STAGES
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [dcmc_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic cmp_a_raw,
    input wire logic cmp_b_raw,
    output logic cmp_a_enable,
    output logic cmp_b_enable,
    output dcmc_pkg::dcmc_node_t cmp_a_inverting_node_sel,
    output dcmc_pkg::dcmc_node_t cmp_a_noninverting_node_sel,
    output dcmc_pkg::dcmc_node_t cmp_b_inverting_node_sel,
    output dcmc_pkg::dcmc_node_t cmp_b_noninverting_node_sel,
    output logic cmp_input_pins_analog,
    output logic cmp_a_out_pin,
    output logic cmp_a_out_oe,
    output logic cmp_b_out_pin,
    output logic cmp_b_out_oe
);
    import dcmc_pkg::*;

    if (SYNC_DEPTH < 2) begin : g_depth_check
        $error("dcmc_top: SYNC_DEPTH must be at least 2");
    end

    // Raw change to result bit, in clock edges
    localparam int LAT = SYNC_DEPTH + 1;

    // Configuration register
    logic [CTRL_W-1:0] ctrl_q;
    logic [CTRL_W-1:0] ctrl_d;
    logic [2:0] mode;
    logic input_switch_select;
    logic inv_a;
    logic inv_b;

    // Bus pipeline
    logic wr_pend_q;
    logic [31:0] hrdata_q;
    logic [31:0] rd_word;
    logic ap_valid;
    logic ap_hit;
    logic ap_lane_ok;

    // Result path
    logic [SYNC_DEPTH-1:0][1:0] sync_q;
    logic [1:0] res_q;
    logic [1:0] res_d;

    // Mode decode
    logic mode_off;
    logic mux_three;
    logic mux_four;
    logic shared_ref;

    assign mode = ctrl_q[MODE_MSB:MODE_LSB];
    assign input_switch_select = ctrl_q[SWITCH_BIT];
    assign inv_a = ctrl_q[INV_A_BIT];
    assign inv_b = ctrl_q[INV_B_BIT];

    assign mode_off = (mode == MODE_OFF_ANALOG)
        || (mode == MODE_OFF_DIGITAL);
    assign mux_three = (mode == MODE_THREE_MUX);
    assign mux_four = (mode == MODE_FOUR_MUX);
    assign shared_ref = (mode == MODE_COMMON_REF)
        || (mode == MODE_COMMON_OUT) || mux_three;

    // Single comparator mode keeps only B alive
    assign cmp_a_enable = !mode_off && (mode != MODE_ONE_INDEP);
    assign cmp_b_enable = !mode_off;
    assign cmp_input_pins_analog = (mode != MODE_OFF_DIGITAL);

    assign cmp_a_inverting_node_sel = (mux_three || mux_four)
        ? (input_switch_select ? NODE_POS_PIN : NODE_NEG_PIN) : NODE_NEG_PIN;
    assign cmp_b_inverting_node_sel = mux_four
        ? (input_switch_select ? NODE_POS_PIN : NODE_NEG_PIN) : NODE_NEG_PIN;

    assign cmp_a_noninverting_node_sel = mux_four ? NODE_FIXED_REF
        : (shared_ref ? NODE_SHARED_PIN : NODE_POS_PIN);
    assign cmp_b_noninverting_node_sel = mux_four ? NODE_FIXED_REF
        : ((mode == MODE_ONE_INDEP) && input_switch_select)
        ? NODE_FIXED_REF : NODE_POS_PIN;

    // Outputs reach pins only in the shared-reference output mode
    assign cmp_a_out_oe = (mode == MODE_COMMON_OUT);
    assign cmp_b_out_oe = (mode == MODE_COMMON_OUT);
    assign cmp_a_out_pin = res_q[0];
    assign cmp_b_out_pin = res_q[1];

    // Raw analog outputs are asynchronous; first stage feeds only the next
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sync_q <= '0;
        end else begin
            sync_q <= {sync_q[SYNC_DEPTH-2:0], {cmp_b_raw, cmp_a_raw}};
        end
    end

    // Disabled comparators report zero before inversion
    assign res_d[0] = (cmp_a_enable & sync_q[SYNC_DEPTH-1][0])
        ^ inv_a;
    assign res_d[1] = (cmp_b_enable & sync_q[SYNC_DEPTH-1][1])
        ^ inv_b;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            res_q <= 2'h0;
        end else begin
            res_q <= res_d;
        end
    end

    // AHB-Lite slave, zero wait states, always OKAY
    assign ap_valid = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign ap_hit = (haddr[ADDR_W-1:2] == CFG_ADDR[ADDR_W-1:2]);
    assign ap_lane_ok = (hsize == HSIZE_WORD) || (haddr[1:0] == 2'h0);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    // Forward a write in its data phase to a read right behind it
    // Write data arrives one cycle after its address
    assign ctrl_d = wr_pend_q ? hwdata[CTRL_W-1:0] : ctrl_q;
    assign rd_word = {24'h00_0000, res_q[1], res_q[0], ctrl_d};

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wr_pend_q <= 1'b0;
        end else begin
            wr_pend_q <= ap_valid && hwrite && ap_hit && ap_lane_ok;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // Unmapped reads return zero
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            hrdata_q <= 32'h0000_0000;
        end else if (ap_valid && !hwrite) begin
            hrdata_q <= ap_hit ? rd_word : 32'h0000_0000;
        end
    end

    // Checking helpers: cycles since the control byte last changed
    logic [3:0] calm_q;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            calm_q <= 4'h0;
        end else if (ctrl_d != ctrl_q) begin
            calm_q <= 4'h0;
        end else if (calm_q != 4'hF) begin
            calm_q <= calm_q + 4'h1;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    // Result checks wait for a settled control byte
    a_res_b_plain: assert property (
        (calm_q > 4'(LAT)) && cmp_b_enable && !inv_b
        |-> res_q[1] == $past(cmp_b_raw, LAT))
        else $error("Result B does not follow comparator B");

    a_res_a_plain: assert property (
        (calm_q > 4'(LAT)) && cmp_a_enable && !inv_a
        |-> res_q[0] == $past(cmp_a_raw, LAT))
        else $error("Result A does not follow comparator A");

    a_res_b_inverted: assert property (
        (calm_q > 4'(LAT)) && cmp_b_enable && inv_b
        |-> res_q[1] == !$past(cmp_b_raw, LAT))
        else $error("Result B not inverted");

    a_res_a_inverted: assert property (
        (calm_q > 4'(LAT)) && cmp_a_enable && inv_a
        |-> res_q[0] == !$past(cmp_a_raw, LAT))
        else $error("Result A not inverted");

    // Node routing per mode
    a_four_mux_switch: assert property (
        mode == MODE_FOUR_MUX |->
        cmp_a_inverting_node_sel == (input_switch_select ? NODE_POS_PIN : NODE_NEG_PIN)
        && cmp_b_inverting_node_sel == cmp_a_inverting_node_sel)
        else $error("Four-input switch routing wrong");

    a_three_mux_switch: assert property (
        mode == MODE_THREE_MUX |->
        cmp_a_inverting_node_sel == (input_switch_select ? NODE_POS_PIN : NODE_NEG_PIN))
        else $error("Three-input switch routing wrong");

    a_single_ref_route: assert property (
        mode == MODE_ONE_INDEP |->
        cmp_b_noninverting_node_sel ==
        (input_switch_select ? NODE_FIXED_REF : NODE_POS_PIN) && !cmp_a_enable)
        else $error("Single comparator reference routing wrong");

    a_off_modes: assert property (
        mode_off |-> !cmp_a_enable && !cmp_b_enable
        && cmp_input_pins_analog == (mode == MODE_OFF_ANALOG))
        else $error("Off mode leaves a comparator on");

    a_shared_out_drive: assert property (
        cmp_a_out_oe |-> mode == MODE_COMMON_OUT && cmp_a_enable
        && cmp_b_enable && cmp_a_noninverting_node_sel == NODE_SHARED_PIN)
        else $error("Output pins driven outside output mode");

    // Bus side refusals and forwarding
    a_cfg_write: assert property (
        ap_valid && hwrite && ap_hit && hsize == HSIZE_WORD
        ##1 1'b1 |=> ctrl_q == $past(hwdata[CTRL_W-1:0]))
        else $error("Control write not stored");

    a_read_result: assert property (
        ap_valid && !hwrite && ap_hit && !wr_pend_q
        |=> hrdata[RES_B_BIT:RES_A_BIT] == $past(res_q)
        && hrdata[CTRL_W-1:0] == $past(ctrl_q))
        else $error("Read data does not show state");

    a_three_mux_pins: assert property (
        mux_three |-> cmp_a_noninverting_node_sel == NODE_SHARED_PIN
        && cmp_b_inverting_node_sel == NODE_NEG_PIN
        && cmp_b_noninverting_node_sel == NODE_POS_PIN)
        else $error("Three-input mode pin use wrong");

    a_four_mux_pins: assert property (
        mux_four |-> cmp_a_noninverting_node_sel == NODE_FIXED_REF
        && cmp_b_noninverting_node_sel == NODE_FIXED_REF
        && cmp_a_enable && cmp_b_enable)
        else $error("Four-input mode pin use wrong");

    a_common_ref_route: assert property (
        mode == MODE_COMMON_REF |-> cmp_a_enable && cmp_b_enable
        && cmp_a_noninverting_node_sel == NODE_SHARED_PIN
        && cmp_a_inverting_node_sel == NODE_NEG_PIN
        && !cmp_a_out_oe)
        else $error("Common reference routing wrong");

    a_two_indep_route: assert property (
        mode == MODE_TWO_INDEP |-> cmp_a_enable && cmp_b_enable
        && cmp_a_inverting_node_sel == NODE_NEG_PIN
        && cmp_a_noninverting_node_sel == NODE_POS_PIN
        && cmp_b_inverting_node_sel == NODE_NEG_PIN
        && cmp_b_noninverting_node_sel == NODE_POS_PIN)
        else $error("Independent comparators share a pin");

    a_single_b_only: assert property (
        mode == MODE_ONE_INDEP |-> cmp_b_enable
        && cmp_b_inverting_node_sel == NODE_NEG_PIN && !cmp_b_out_oe)
        else $error("Single comparator mode wrong");

    a_idle_inverting: assert property (
        !mux_three && !mux_four
        |-> cmp_a_inverting_node_sel == NODE_NEG_PIN
        && cmp_b_inverting_node_sel == NODE_NEG_PIN)
        else $error("Switch bit acts outside its modes");

    a_analog_pins: assert property (
        mode != MODE_OFF_DIGITAL |-> cmp_input_pins_analog)
        else $error("Pins released outside digital off mode");

    a_out_pin_b: assert property (
        cmp_b_out_oe |-> cmp_b_enable && cmp_b_out_pin == res_q[1])
        else $error("Output pin B does not show result");

    // A powered-down comparator reads as its inversion bit alone
    a_res_a_off: assert property (
        (calm_q > 4'h1) && !cmp_a_enable |-> res_q[0] == inv_a)
        else $error("Result A of an off comparator wrong");

    a_res_b_off: assert property (
        (calm_q > 4'h1) && !cmp_b_enable |-> res_q[1] == inv_b)
        else $error("Result B of an off comparator wrong");

    a_read_forward: assert property (
        wr_pend_q && ap_valid && !hwrite && ap_hit
        |=> hrdata[CTRL_W-1:0] == $past(hwdata[CTRL_W-1:0]))
        else $error("Read right after write shows old byte");

    a_unmapped_read: assert property (
        ap_valid && !hwrite && !ap_hit |=> hrdata == 32'h0000_0000)
        else $error("Unmapped read not zero");

    a_write_refused: assert property (
        ap_valid && hwrite && (!ap_hit || !ap_lane_ok) |=> !wr_pend_q)
        else $error("Refused write accepted");

    a_ctrl_hold: assert property (
        !wr_pend_q |=> $stable(ctrl_q))
        else $error("Control byte changed without a write");

    // Both raw outputs cross as a pair through the same stages
    a_sync_path: assert property (
        (calm_q > 4'(LAT)) |-> sync_q[SYNC_DEPTH-1]
        == $past({cmp_b_raw, cmp_a_raw}, SYNC_DEPTH))
        else $error("Synchroniser depth wrong");

    // Main scenarios worth seeing in coverage

    c_four_mux_write: cover property (
        wr_pend_q ##1 mode == MODE_FOUR_MUX && input_switch_select);
    c_output_mode: cover property (cmp_a_out_oe && res_q == 2'h3);
    c_result_b_rise: cover property (
        cmp_b_enable ##1 $rose(res_q[1]));
    c_write_then_read: cover property (
        wr_pend_q && ap_valid && !hwrite && ap_hit);
    c_single_ref: cover property (mode == MODE_ONE_INDEP && input_switch_select);

endmodule

/* rtl/dcmc_pkg.sv */
package dcmc_pkg;

    // Bus side
    localparam int ADDR_W = 32;
    localparam logic [ADDR_W-1:0] CFG_ADDR = 32'h0000_009C;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // Control byte layout
    localparam int RES_B_BIT = 7;
    localparam int RES_A_BIT = 6;
    localparam int INV_B_BIT = 5;
    localparam int INV_A_BIT = 4;
    localparam int SWITCH_BIT = 3;
    localparam int MODE_MSB = 2;
    localparam int MODE_LSB = 0;
    localparam int CTRL_W = 6;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

    // Comparator mode codes
    localparam logic [2:0] MODE_OFF_ANALOG = 3'h0;
    localparam logic [2:0] MODE_THREE_MUX = 3'h1;
    localparam logic [2:0] MODE_FOUR_MUX = 3'h2;
    localparam logic [2:0] MODE_COMMON_REF = 3'h3;
    localparam logic [2:0] MODE_TWO_INDEP = 3'h4;
    localparam logic [2:0] MODE_ONE_INDEP = 3'h5;
    localparam logic [2:0] MODE_COMMON_OUT = 3'h6;
    localparam logic [2:0] MODE_OFF_DIGITAL = 3'h7;

    // Synchroniser depth on the raw comparator outputs
    localparam int SYNC_STAGES = 2;

    // Source steered onto a comparator node
    typedef enum logic [1:0] {
        NODE_NEG_PIN,
        NODE_POS_PIN,
        NODE_FIXED_REF,
        NODE_SHARED_PIN
    } dcmc_node_t;

endpackage

/* test/dcmc_cmp_model.sv */
// Behavioural pair of comparators with their input pins
module dcmc_cmp_model
    import dcmc_pkg::*;
(
    input wire logic a_en,
    input wire logic b_en,
    input wire dcmc_node_t a_inv_sel,
    input wire dcmc_node_t a_ninv_sel,
    input wire dcmc_node_t b_inv_sel,
    input wire dcmc_node_t b_ninv_sel,
    input wire logic [5:0][7:0] v,
    output logic a_raw,
    output logic b_raw
);
    // Levels: 0 a plus, 1 a minus, 2 b plus, 3 b minus, 4 ref, 5 shared
    function automatic logic [7:0] pick(dcmc_node_t s, logic [7:0] p,
        logic [7:0] m, logic [5:0][7:0] lv);
        case (s)
            NODE_POS_PIN: return p;
            NODE_NEG_PIN: return m;
            NODE_FIXED_REF: return lv[4];
            default: return lv[5];
        endcase
    endfunction
    // Powered-down comparator gives a low output
    assign a_raw = a_en && (pick(a_ninv_sel, v[0], v[1], v)
        > pick(a_inv_sel, v[0], v[1], v));
    assign b_raw = b_en && (pick(b_ninv_sel, v[2], v[3], v)
        > pick(b_inv_sel, v[2], v[3], v));
endmodule

/* test/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import dcmc_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = HSIZE_WORD;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [5:0][7:0] v = 48'h1030_6020_4080;
    logic hreadyout, hresp, a_raw, b_raw, a_en, b_en, pins_analog;
    logic a_out, a_oe, b_out, b_oe;
    logic [31:0] hrdata;
    dcmc_node_t a_inv, a_ninv, b_inv, b_ninv;
    int failures = 0;
    int total_checks = 0;
    int cyc = 0;
    always #2.5 mclk = ~mclk;
    dcmc_top dut (.mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .cmp_a_raw(a_raw), .cmp_b_raw(b_raw),
        .cmp_a_enable(a_en), .cmp_b_enable(b_en),
        .cmp_a_inverting_node_sel(a_inv),
        .cmp_a_noninverting_node_sel(a_ninv),
        .cmp_b_inverting_node_sel(b_inv),
        .cmp_b_noninverting_node_sel(b_ninv),
        .cmp_input_pins_analog(pins_analog), .cmp_a_out_pin(a_out),
        .cmp_a_out_oe(a_oe), .cmp_b_out_pin(b_out), .cmp_b_out_oe(b_oe));
    dcmc_cmp_model far_side (.a_en(a_en), .b_en(b_en), .a_inv_sel(a_inv),
        .a_ninv_sel(a_ninv), .b_inv_sel(b_inv), .b_ninv_sel(b_ninv),
        .v(v), .a_raw(a_raw), .b_raw(b_raw));
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // Address phase held until hready, then data phase until hready
    task automatic bus(logic w, logic [31:0] a, logic [31:0] d,
        output logic [31:0] r);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        r = hrdata;
        hsel <= 1'b0;
        #1;
    endtask
    task automatic wr(logic [31:0] a, logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd_chk(string n, logic [31:0] a, logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0000_0000, r);
        chk(n, r, e);
    endtask
    task automatic t_reset;
        rd_chk("cfg_reset", CFG_ADDR, 32'h0000_0000);
        chk("analog_reset", pins_analog, 1'b1);
        chk("oe_reset", {a_oe, b_oe, a_en, b_en}, 4'h0);
        chk("okay", {hreadyout, hresp}, 2'h2);
        $display("reset test done");
    endtask
    task automatic t_modes;
        logic [2:0] m;
        for (int i = 0; i < 8; i++) begin
            m = i[2:0];
            wr(CFG_ADDR, {29'h0, m});
            chk("a_en", a_en, m inside {1, 2, 3, 4, 6});
            chk("b_en", b_en, m != 0 && m != 7);
            chk("analog", pins_analog, m != 7);
            chk("oe", {a_oe, b_oe}, {2{m == 6}});
            chk("a_ninv", a_ninv, (m inside {1, 3, 6}) ? NODE_SHARED_PIN
                : (m == 2) ? NODE_FIXED_REF : NODE_POS_PIN);
            chk("b_ninv", b_ninv, (m == 2) ? NODE_FIXED_REF
                : NODE_POS_PIN);
            rd_chk("mode", CFG_ADDR, {29'h0, m});
        end
        $display("mode test done");
    endtask
    task automatic t_switch;
        wr(CFG_ADDR, 32'h0000_000A);
        chk("sw4_on", {a_inv, b_inv}, {NODE_POS_PIN, NODE_POS_PIN});
        wr(CFG_ADDR, 32'h0000_0002);
        chk("sw4_off", {a_inv, b_inv}, {NODE_NEG_PIN, NODE_NEG_PIN});
        wr(CFG_ADDR, 32'h0000_0009);
        chk("sw3_on", a_inv, NODE_POS_PIN);
        wr(CFG_ADDR, 32'h0000_0001);
        chk("sw3_off", a_inv, NODE_NEG_PIN);
        wr(CFG_ADDR, 32'h0000_000D);
        chk("sw1_on", b_ninv, NODE_FIXED_REF);
        wr(CFG_ADDR, 32'h0000_0005);
        chk("sw1_off", b_ninv, NODE_POS_PIN);
        $display("switch test done");
    endtask
    // Levels make A high and B low in independent mode
    task automatic t_result;
        wr(CFG_ADDR, 32'h0000_00C4);
        repeat (4) @(posedge mclk);
        rd_chk("res_plain", CFG_ADDR, 32'h0000_0044);
        wr(CFG_ADDR, 32'h0000_0034);
        repeat (4) @(posedge mclk);
        rd_chk("res_inv", CFG_ADDR, 32'h0000_00B4);
        chk("out_pins", {a_out, b_out}, 2'h1);
        $display("result test done");
    endtask
    task automatic t_sync;
        wr(CFG_ADDR, 32'h0000_0004);
        repeat (4) @(posedge mclk);
        #1;
        chk("a_before", a_out, 1'b1);
        @(posedge mclk);
        v[1] <= 8'hF0;
        repeat (2) @(posedge mclk);
        #1;
        chk("a_sync_hold", a_out, 1'b1);
        @(posedge mclk);
        #1;
        chk("a_sync_new", a_out, 1'b0);
        @(posedge mclk);
        v[1] <= 8'h40;
        $display("sync test done");
    endtask
    task automatic t_mid_reset;
        wr(CFG_ADDR, 32'h0000_003E);
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        chk("mid_oe", {a_oe, b_oe, a_en, b_en}, 4'h0);
        @(posedge mclk);
        nrst <= 1'b1;
        rd_chk("mid_cfg", CFG_ADDR, 32'h0000_0000);
        $display("mid reset test done");
    endtask
    task automatic t_unmapped;
        wr(CFG_ADDR, 32'h0000_0000);
        wr(32'h0000_00A0, 32'h0000_0007);
        rd_chk("cfg_kept", CFG_ADDR, 32'h0000_0000);
        rd_chk("unmapped", 32'h0000_00A0, 32'h0000_0000);
        $display("unmapped test done");
    endtask
    task automatic end_sim;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Whole run needs under 150 cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            end_sim();
        end
    end
    initial begin
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        t_reset();
        t_modes();
        t_switch();
        t_result();
        t_sync();
        t_unmapped();
        t_mid_reset();
        end_sim();
    end
endmodule
